// file: hw/vt_supervisor_defs.vh
`ifndef VT_SUPERVISOR_DEFS_VH
`define VT_SUPERVISOR_DEFS_VH

// ==========================================================
// clock and timing base
// ==========================================================
`define CLK_PERIOD_NS   40
`define MS_IN_NS        1000000
`define TICK_CYCLES_DEF (`MS_IN_NS / `CLK_PERIOD_NS)

// ==========================================================
// supervision timers, in milliseconds
// ==========================================================
`define ARM_DELAY_MS    8'hC8
`define QUAL_DELAY_MS   8'h04
`define CLEAR_DELAY_MS  8'hC8
`define LATCH_AGE_MS    8'h64

// ==========================================================
// failure criterion select
// ==========================================================
`define MODE_ZERO_SEQ   2'h0
`define MODE_NEG_SEQ    2'h1
`define MODE_SPECIAL    2'h2

// ==========================================================
// setting defaults and limits, in percent
// ==========================================================
`define VOLT_THR_DEF    7'h3C
`define CURR_THR_DEF    7'h0A
`define VOLT_THR_MIN    7'h0A
`define CURR_THR_MIN    7'h02
`define THR_MAX         7'h64

`endif

// file: hw/vt_circuit_failure_supervisor.v
// Notes on behaviour
// - dead line needs all voltages and currents low
// - live line needs all three voltages high
// - per-phase voltage start flags above threshold
// - per-phase current start flags above threshold
// - block input suppresses both line conditions
// - zero-seq: residual voltage high, current low
// - neg-seq: negseq voltage high, current low
// - special: residual voltage high, both currents low
// - arm after live line held 200 ms
// - dead line disarms the supervisor unless the failure latches
// - armed, criterion held 4 ms sets failure
// - supervisor runs only if enabled and unblocked
// - live line, criterion gone 200 ms clears failure
// - dead line after 100 ms failure latches output
// - dead line before 100 ms failure clears output
// - no event records generated here
// - operation setting off/on enables line-state logic
`timescale 1ns/1ps
`default_nettype none
`include "vt_supervisor_defs.vh"

module vt_circuit_failure_supervisor #(
    parameter integer MAG_W       = 16,
    parameter integer FRAC_W      = 8,
    parameter integer TICK_CYCLES = `TICK_CYCLES_DEF
) (
    input  wire             i_clk,                     // 25 MHz block clock
    input  wire             i_reset_n,                 // async reset, active low
    input  wire             i_operation_on,            // operation setting
    input  wire             i_line_state_block_in,     // block input
    input  wire [1:0]       i_mode,                    // criterion select
    input  wire [6:0]       i_voltage_threshold_setting, // percent
    input  wire [6:0]       i_current_threshold_setting, // percent
    input  wire [MAG_W-1:0] i_phase1_voltage,          // magnitude, percent
    input  wire [MAG_W-1:0] i_phase2_voltage,          // magnitude, percent
    input  wire [MAG_W-1:0] i_phase3_voltage,          // magnitude, percent
    input  wire [MAG_W-1:0] i_phase1_current,          // magnitude, percent
    input  wire [MAG_W-1:0] i_phase2_current,          // magnitude, percent
    input  wire [MAG_W-1:0] i_phase3_current,          // magnitude, percent
    input  wire [MAG_W-1:0] i_residual_voltage,        // magnitude, percent
    input  wire [MAG_W-1:0] i_residual_current,        // magnitude, percent
    input  wire [MAG_W-1:0] i_negseq_voltage,          // magnitude, percent
    input  wire [MAG_W-1:0] i_negseq_current,          // magnitude, percent
    output reg              o_phase1_voltage_start,    // U1 above threshold
    output reg              o_phase2_voltage_start,    // U2 above threshold
    output reg              o_phase3_voltage_start,    // U3 above threshold
    output reg              o_phase1_current_start,    // I1 above threshold
    output reg              o_phase2_current_start,    // I2 above threshold
    output reg              o_phase3_current_start,    // I3 above threshold
    output reg              o_dead_line_flag,          // dead line state
    output reg              o_live_line_flag,          // live line state
    output reg              o_supervisor_armed,        // supervision armed
    output reg              o_circuit_failure_out      // circuit failure
);

    // ==========================================================
    // states
    // ==========================================================
    localparam [1:0] ST_DISARMED = 2'h0;
    localparam [1:0] ST_ARMED    = 2'h1;
    localparam [1:0] ST_FAIL     = 2'h2;
    localparam [1:0] ST_LATCHED  = 2'h3;

    localparam [15:0] TICK_LAST = TICK_CYCLES[15:0] - 16'h0001;

    // ==========================================================
    // timer limits, in ms ticks
    // ==========================================================
    localparam [7:0] ARM_LIMIT   = `ARM_DELAY_MS;
    localparam [7:0] QUAL_LIMIT  = `QUAL_DELAY_MS;
    localparam [7:0] CLEAR_LIMIT = `CLEAR_DELAY_MS;
    localparam [7:0] LATCH_LIMIT = `LATCH_AGE_MS;

    // ==========================================================
    // helpers
    // ==========================================================
    // percent setting placed on the magnitude's fixed-point grid
    function [MAG_W-1:0] scale_thr;
        input [6:0] thr;
        begin
            scale_thr = {{(MAG_W-7-FRAC_W){1'b0}}, thr, {FRAC_W{1'b0}}};
        end
    endfunction

    // saturating millisecond step, stops at 8'hFF
    function [7:0] ms_step;
        input [7:0] cnt;
        input       tick;
        begin
            if (tick && cnt != 8'hFF) begin
                ms_step = cnt + 8'h01;
            end else begin
                ms_step = cnt;
            end
        end
    endfunction

    // strict compares: equal to the threshold is neither above nor below
    function above;
        input [MAG_W-1:0] mag;
        input [MAG_W-1:0] thr;
        begin
            above = mag > thr;
        end
    endfunction

    function below;
        input [MAG_W-1:0] mag;
        input [MAG_W-1:0] thr;
        begin
            below = mag < thr;
        end
    endfunction

    // past the limit, so N+1 ticks: at least N ms whatever the tick phase
    function expired;
        input [7:0] cnt;
        input [7:0] lim;
        begin
            expired = cnt > lim;
        end
    endfunction

    // ==========================================================
    // reset release
    // ==========================================================
    reg rst_meta_r;
    reg rst_sync_r;

    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    wire rst_n = rst_sync_r;

    // ==========================================================
    // 1 ms tick
    // ==========================================================
    reg [15:0] tick_cnt_r;
    reg        tick_r;

    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_r <= 16'h0000;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r == TICK_LAST) begin
            tick_cnt_r <= 16'h0000;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 16'h0001;
            tick_r     <= 1'b0;
        end
    end

    // ==========================================================
    // line-state comparisons
    // ==========================================================
    // settings outside their range are the setting source's to avoid
    wire [MAG_W-1:0] u_thr = scale_thr(i_voltage_threshold_setting);
    wire [MAG_W-1:0] i_thr = scale_thr(i_current_threshold_setting);

    wire enabled = i_operation_on && !i_line_state_block_in;

    wire u1_hi = above(i_phase1_voltage, u_thr);
    wire u2_hi = above(i_phase2_voltage, u_thr);
    wire u3_hi = above(i_phase3_voltage, u_thr);
    wire c1_hi = above(i_phase1_current, i_thr);
    wire c2_hi = above(i_phase2_current, i_thr);
    wire c3_hi = above(i_phase3_current, i_thr);
    wire u1_lo = below(i_phase1_voltage, u_thr);
    wire u2_lo = below(i_phase2_voltage, u_thr);
    wire u3_lo = below(i_phase3_voltage, u_thr);
    wire c1_lo = below(i_phase1_current, i_thr);
    wire c2_lo = below(i_phase2_current, i_thr);
    wire c3_lo = below(i_phase3_current, i_thr);

    wire dead_now = u1_lo && u2_lo && u3_lo && c1_lo && c2_lo && c3_lo;
    wire live_now = u1_hi && u2_hi && u3_hi;

    // outputs go quiet while the line-state logic is disabled
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_phase1_voltage_start <= 1'b0;
            o_phase2_voltage_start <= 1'b0;
            o_phase3_voltage_start <= 1'b0;
            o_phase1_current_start <= 1'b0;
            o_phase2_current_start <= 1'b0;
            o_phase3_current_start <= 1'b0;
            o_dead_line_flag       <= 1'b0;
            o_live_line_flag       <= 1'b0;
        end else begin
            o_phase1_voltage_start <= enabled && u1_hi;
            o_phase2_voltage_start <= enabled && u2_hi;
            o_phase3_voltage_start <= enabled && u3_hi;
            o_phase1_current_start <= enabled && c1_hi;
            o_phase2_current_start <= enabled && c2_hi;
            o_phase3_current_start <= enabled && c3_hi;
            o_dead_line_flag       <= enabled && dead_now;
            o_live_line_flag       <= enabled && live_now;
        end
    end

    // ==========================================================
    // failure criterion
    // ==========================================================
    wire res_u_hi = above(i_residual_voltage, u_thr);
    wire res_i_lo = below(i_residual_current, i_thr);
    wire neg_u_hi = above(i_negseq_voltage, u_thr);
    wire neg_i_lo = below(i_negseq_current, i_thr);

    reg crit;

    always @* begin
        case (i_mode)
            `MODE_NEG_SEQ: begin
                crit = neg_u_hi && neg_i_lo;
            end
            `MODE_SPECIAL: begin
                crit = res_u_hi && res_i_lo && neg_i_lo;
            end
            default: begin
                crit = res_u_hi && res_i_lo;
            end
        endcase
    end

    // ==========================================================
    // supervision core
    // ==========================================================
    // timers need N+1 ticks: the first tick may land early, so the
    // held time is at least N ms and under N+1 ms
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [7:0] arm_cnt_r;
    reg [7:0] arm_cnt_nxt;
    reg [7:0] qual_cnt_r;
    reg [7:0] qual_cnt_nxt;
    reg [7:0] clr_cnt_r;
    reg [7:0] clr_cnt_nxt;
    reg [7:0] age_cnt_r;
    reg [7:0] age_cnt_nxt;
    reg       dead_d_r;

    wire live = o_live_line_flag;
    wire dead = o_dead_line_flag;
    wire dead_start = dead && !dead_d_r;

    always @* begin
        state_nxt    = state_r;
        arm_cnt_nxt  = 8'h00;
        qual_cnt_nxt = 8'h00;
        clr_cnt_nxt  = 8'h00;
        age_cnt_nxt  = age_cnt_r;
        case (state_r)
            ST_DISARMED: begin
                age_cnt_nxt = 8'h00;
                if (live) begin
                    arm_cnt_nxt = ms_step(arm_cnt_r, tick_r);
                end
                if (expired(arm_cnt_r, ARM_LIMIT)) begin
                    state_nxt   = ST_ARMED;
                    arm_cnt_nxt = 8'h00;
                end
            end
            ST_ARMED: begin
                age_cnt_nxt = 8'h00;
                if (crit) begin
                    qual_cnt_nxt = ms_step(qual_cnt_r, tick_r);
                end
                if (dead) begin
                    state_nxt = ST_DISARMED;
                end else if (expired(qual_cnt_r, QUAL_LIMIT)) begin
                    state_nxt = ST_FAIL;
                end
            end
            ST_FAIL: begin
                age_cnt_nxt = ms_step(age_cnt_r, tick_r);
                if (live && !crit) begin
                    clr_cnt_nxt = ms_step(clr_cnt_r, tick_r);
                end
                if (dead_start) begin
                    if (expired(age_cnt_r, LATCH_LIMIT)) begin
                        state_nxt = ST_LATCHED;
                    end else begin
                        state_nxt = ST_DISARMED;
                    end
                end else if (expired(clr_cnt_r, CLEAR_LIMIT)) begin
                    state_nxt = ST_ARMED;
                end
            end
            ST_LATCHED: begin
                // held through the open period; reclosing resumes
                // the live-line clearing path
                if (live) begin
                    state_nxt = ST_FAIL;
                end
            end
            default: begin
                state_nxt = ST_DISARMED;
            end
        endcase
        if (!enabled) begin
            state_nxt   = ST_DISARMED;
            age_cnt_nxt = 8'h00;
        end
    end

    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r               <= ST_DISARMED;
            arm_cnt_r             <= 8'h00;
            qual_cnt_r            <= 8'h00;
            clr_cnt_r             <= 8'h00;
            age_cnt_r             <= 8'h00;
            dead_d_r              <= 1'b0;
            o_supervisor_armed    <= 1'b0;
            o_circuit_failure_out <= 1'b0;
        end else begin
            state_r               <= state_nxt;
            arm_cnt_r             <= arm_cnt_nxt;
            qual_cnt_r            <= qual_cnt_nxt;
            clr_cnt_r             <= clr_cnt_nxt;
            age_cnt_r             <= age_cnt_nxt;
            dead_d_r              <= dead;
            o_supervisor_armed    <= state_nxt != ST_DISARMED;
            // no event logic: downstream blocks watch this level
            o_circuit_failure_out <= state_nxt == ST_FAIL ||
                                     state_nxt == ST_LATCHED;
        end
    end

endmodule

`default_nettype wire

// file: bench/upstream_magnitude_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// upstream stage: one register of pipeline latency
// ==================================================
module upstream_magnitude_model (
    input  wire logic             i_clk,  // block clock
    input  wire logic [9:0][7:0]  i_pct,  // whole percent per quantity
    input  wire logic [7:0]       i_frac, // shared fraction bits
    output var  logic [9:0][15:0] o_mag   // percent times 256
);
    always @(posedge i_clk) begin
        for (int k = 0; k < 10; k++) begin
            o_mag[k] <= {i_pct[k], i_frac};
        end
    end
endmodule
`default_nettype wire

// file: bench/vt_supervisor_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// line-state and supervision checks
// ==================================================
module vt_supervisor_checker #(
    parameter integer MAG_W       = 16,
    parameter integer FRAC_W      = 8,
    parameter integer TICK_CYCLES = 25000
) (
    input wire logic             i_clk, i_reset_n, i_operation_on, i_line_state_block_in,
    input wire logic [1:0]       i_mode,
    input wire logic [6:0]       i_voltage_threshold_setting, i_current_threshold_setting,
    input wire logic [MAG_W-1:0] i_phase1_voltage, i_phase2_voltage, i_phase3_voltage,
    input wire logic [MAG_W-1:0] i_phase1_current, i_phase2_current, i_phase3_current,
    input wire logic [MAG_W-1:0] i_residual_voltage, i_residual_current,
    input wire logic [MAG_W-1:0] i_negseq_voltage, i_negseq_current,
    input wire logic             o_dead_line_flag, o_live_line_flag,
    input wire logic             o_supervisor_armed, o_circuit_failure_out
);
    wire [MAG_W-1:0] vt = MAG_W'(i_voltage_threshold_setting) << FRAC_W;
    wire [MAG_W-1:0] it = MAG_W'(i_current_threshold_setting) << FRAC_W;
    wire en = i_operation_on && !i_line_state_block_in;
    wire uhi = i_phase1_voltage > vt && i_phase2_voltage > vt && i_phase3_voltage > vt;
    wire ulo = i_phase1_voltage < vt && i_phase2_voltage < vt && i_phase3_voltage < vt;
    wire ilo = i_phase1_current < it && i_phase2_current < it && i_phase3_current < it;
    wire rv = i_residual_voltage > vt && i_residual_current < it;
    wire crit = (i_mode == 2'h1) ? (i_negseq_voltage > vt && i_negseq_current < it)
              : (rv && (i_mode != 2'h2 || i_negseq_current < it));
    // long holds counted here, far past what a repetition may unroll
    logic [2:0]  age_r;
    logic [31:0] live_r, crit_r, ncrit_r, fail_r;
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            age_r   <= 3'h0;
            live_r  <= 32'h0;
            crit_r  <= 32'h0;
            ncrit_r <= 32'h0;
            fail_r  <= 32'h0;
        end else begin
            age_r   <= (age_r == 3'h7) ? age_r : age_r + 3'h1;
            live_r  <= o_live_line_flag ? live_r + 32'h1 : 32'h0;
            crit_r  <= crit ? crit_r + 32'h1 : 32'h0;
            ncrit_r <= crit ? 32'h0 : ncrit_r + 32'h1;
            fail_r  <= o_circuit_failure_out ? fail_r + 32'h1 : 32'h0;
        end
    end
    // design holds its own reset two edges longer, so wait it out
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n || age_r != 3'h7);
    live_flag_a: assert property (o_live_line_flag == $past(en && uhi))
        else $error("live flag wrong");
    dead_flag_a: assert property (o_dead_line_flag == $past(en && ulo && ilo))
        else $error("dead flag wrong");
    disable_clear_a: assert property (!en ##1 !en |=> !o_supervisor_armed
        && !o_circuit_failure_out) else $error("disabled core still active");
    arm_delay_a: assert property ($rose(o_supervisor_armed)
        |-> live_r >= 200 * TICK_CYCLES) else $error("armed too early");
    disarm_dead_a: assert property ($rose(o_dead_line_flag) && !o_circuit_failure_out
        |-> ##[1:3] !o_supervisor_armed) else $error("dead line left core armed");
    qualify_a: assert property ($rose(o_circuit_failure_out)
        |-> $past(o_supervisor_armed) && crit_r >= 4 * TICK_CYCLES) else $error("early failure");
    clear_delay_a: assert property ($fell(o_circuit_failure_out) && o_live_line_flag
        && $past(o_live_line_flag) |-> ncrit_r >= 199 * TICK_CYCLES) else $error("early clear");
    latch_hold_a: assert property ($rose(o_dead_line_flag) && fail_r > 110 * TICK_CYCLES
        |-> ##1 o_circuit_failure_out [*4]) else $error("failure not latched");
    early_clear_a: assert property ($rose(o_dead_line_flag) && o_circuit_failure_out
        && fail_r < 90 * TICK_CYCLES |-> ##[1:4] !o_circuit_failure_out) else $error("not cleared");
    cover property ($rose(o_supervisor_armed));
    cover property ($rose(o_circuit_failure_out) && i_mode == 2'h2);
    cover property ($rose(o_dead_line_flag) && o_circuit_failure_out);
endmodule
bind vt_circuit_failure_supervisor vt_supervisor_checker #(
    .MAG_W(MAG_W), .FRAC_W(FRAC_W), .TICK_CYCLES(TICK_CYCLES)
) u_vt_supervisor_checker (
    .i_clk, .i_reset_n, .i_operation_on, .i_line_state_block_in, .i_mode,
    .i_voltage_threshold_setting, .i_current_threshold_setting,
    .i_phase1_voltage, .i_phase2_voltage, .i_phase3_voltage,
    .i_phase1_current, .i_phase2_current, .i_phase3_current,
    .i_residual_voltage, .i_residual_current, .i_negseq_voltage, .i_negseq_current,
    .o_dead_line_flag, .o_live_line_flag, .o_supervisor_armed, .o_circuit_failure_out
);
`default_nettype wire

// file: bench/test_vt_circuit_failure_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
module test_vt_circuit_failure_supervisor;
    // ==================================================
    // stimulus, partner and design
    // ==================================================
    localparam int TK = 4;
    // sequence bytes packed as {negI, negU, resI, resU}
    localparam logic [31:0] nocrit = 32'h32053205;
    localparam logic [31:0] decoy_tab [4] = '{32'h05500505, 32'h32050550,
                                              32'h32050550, 32'h05500505};
    localparam logic [31:0] crit_tab [4] = '{32'h32050550, 32'h05503205,
                                             32'h05050550, 32'h32050550};
    logic             i_clk = 1'b0;
    logic             i_reset_n = 1'b0;
    logic             op = 1'b0;
    logic             blk = 1'b0;
    logic [1:0]       mode = 2'h0;
    logic [6:0]       vthr = 7'h3C;
    logic [6:0]       ithr = 7'h0A;
    logic [7:0]       frac = 8'h00;
    logic [9:0][7:0]  pct = '0;
    logic [9:0][15:0] mag;
    wire  [9:0]       fl;
    integer           seed = 32'h62AA5377;
    integer           fail_count = 0;
    integer           num_checks = 0;
    integer           k, j, d;
    upstream_magnitude_model u_upstream_magnitude_model (
        .i_clk(i_clk), .i_pct(pct), .i_frac(frac), .o_mag(mag)
    );
    vt_circuit_failure_supervisor #(.TICK_CYCLES(TK)) u_vt_circuit_failure_supervisor (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_operation_on(op),
        .i_line_state_block_in(blk), .i_mode(mode),
        .i_voltage_threshold_setting(vthr), .i_current_threshold_setting(ithr),
        .i_phase1_voltage(mag[0]), .i_phase2_voltage(mag[1]), .i_phase3_voltage(mag[2]),
        .i_phase1_current(mag[3]), .i_phase2_current(mag[4]), .i_phase3_current(mag[5]),
        .i_residual_voltage(mag[6]), .i_residual_current(mag[7]),
        .i_negseq_voltage(mag[8]), .i_negseq_current(mag[9]),
        .o_phase1_voltage_start(fl[0]), .o_phase2_voltage_start(fl[1]),
        .o_phase3_voltage_start(fl[2]), .o_phase1_current_start(fl[3]),
        .o_phase2_current_start(fl[4]), .o_phase3_current_start(fl[5]),
        .o_dead_line_flag(fl[6]), .o_live_line_flag(fl[7]),
        .o_supervisor_armed(fl[8]), .o_circuit_failure_out(fl[9])
    );
    initial begin
        forever #20 i_clk = ~i_clk;
    end
    task cyc;
        @(posedge i_clk);
        #1;
    endtask
    task ms(input int n);
        repeat (n * TK) cyc();
    endtask
    task line(input logic [7:0] u, input logic [7:0] c);
        pct[2:0] = {3{u}};
        pct[5:3] = {3{c}};
    endtask
    task automatic check_vec(input string nm, input logic [9:0] e, input logic [9:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic check_bit(input string nm, input logic e, input logic g);
        check_vec(nm, {9'h000, e}, {9'h000, g});
    endtask
    task automatic wait_bit(input string nm, input int b, input logic v, input int lim);
        int n;
        n = 0;
        while (fl[b] !== v && n < lim * TK) begin
            cyc();
            n++;
        end
        check_bit(nm, v, fl[b]);
    endtask
    // equality with a threshold is neither above nor below
    function automatic logic [9:0] model();
        logic [9:0] r;
        int dv;
        r = '0;
        dv = 1;
        for (int p = 0; p < 6; p++) begin
            r[p] = pct[p] * 256 + frac > (p < 3 ? vthr : ithr) * 256;
            dv = dv && (pct[p] * 256 + frac < (p < 3 ? vthr : ithr) * 256);
        end
        r[6] = dv;
        r[7] = &r[2:0];
        return (op && !blk) ? r : 10'h000;
    endfunction
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        fail_count++;
        final_report();
    end
    initial begin
        repeat (3) cyc();
        i_reset_n = 1'b1;
        repeat (3) cyc();
        check_vec("reset", 10'h000, fl);
        for (k = 0; k < 60; k++) begin
            op = ($random(seed) & 3) != 0;
            blk = ($random(seed) & 7) == 0;
            mode = 2'($random(seed));
            vthr = 7'($unsigned($random(seed)) % 91 + 10);
            ithr = 7'($unsigned($random(seed)) % 99 + 2);
            d = $random(seed) % 4;
            for (j = 0; j < 10; j++) begin
                pct[j] = 8'((j < 3 ? vthr : ithr) + d + ($random(seed) & 1));
            end
            frac = 8'($random(seed) & 32'h7F);
            repeat (3) cyc();
            check_vec("line_flags", model(), {2'b00, fl[7:0]});
        end
        $display("test line_state done");
        op = 1'b0;
        vthr = 7'h3C;
        ithr = 7'h0A;
        frac = 8'h40;
        mode = 2'h0;
        line(8'h50, 8'h32);
        pct[9:6] = nocrit;
        repeat (2) cyc();
        op = 1'b1;
        blk = 1'b0;
        ms(198);
        check_bit("armed_early", 1'b0, fl[8]);
        wait_bit("armed", 8, 1'b1, 8);
        for (k = 0; k < 4; k++) begin
            mode = 2'(k);
            pct[9:6] = decoy_tab[k];
            ms(10);
            check_bit("decoy", 1'b0, fl[9]);
            pct[9:6] = crit_tab[k];
            ms(3);
            check_bit("qual_early", 1'b0, fl[9]);
            wait_bit("fail_set", 9, 1'b1, 6);
            pct[9:6] = nocrit;
            ms(190);
            check_bit("fail_hold", 1'b1, fl[9]);
            wait_bit("fail_clear", 9, 1'b0, 15);
            check_bit("armed_kept", 1'b1, fl[8]);
        end
        $display("test mode_select done");
        mode = 2'h0;
        pct[9:6] = crit_tab[0];
        wait_bit("fail_again", 9, 1'b1, 8);
        ms(110);
        line(8'h05, 8'h05);
        ms(30);
        check_vec("latched", 10'h340, fl);
        op = 1'b0;
        ms(1);
        check_vec("disabled", 10'h000, fl);
        $display("test latch done");
        op = 1'b1;
        line(8'h50, 8'h32);
        pct[9:6] = nocrit;
        wait_bit("rearm", 8, 1'b1, 210);
        pct[9:6] = crit_tab[0];
        wait_bit("fail_early", 9, 1'b1, 8);
        ms(20);
        line(8'h05, 8'h05);
        ms(2);
        check_vec("early_dead", 10'h040, fl);
        line(8'h50, 8'h32);
        pct[9:6] = nocrit;
        wait_bit("rearm_again", 8, 1'b1, 210);
        line(8'h05, 8'h05);
        ms(2);
        check_vec("armed_dead", 10'h040, fl);
        $display("test early_dead done");
        final_report();
    end
endmodule
`default_nettype wire
